// ===== bpe_lane.sv
// Purpose: Parity checker for one bus: holds the phase and tests the
//          parity bit that follows it one clock later.
// Assumes: Parity bit of a phase arrives in the next clock.
// Notes:   Verdicts are valid in the clock after the phase only.
`timescale 1ns/1ps
module bpe_lane
  import bpe_pkg::*;
(
  // Clock and reset
  input wire logic  hclk,
  input wire logic  hresetn,
  // Bus sample
  bpe_lane_if.lane  lif
);

  bpe_lane_state_t st_reg;
  bpe_lane_state_t st_next;
  logic            mismatch;

  always_comb begin
    st_next         = st_reg;
    st_next.ad      = lif.ad;
    st_next.cbe     = lif.cbe;
    st_next.addr_ph = lif.addr_ph;
    st_next.data_ph = lif.data_ph;
    st_next.kind    = lif.kind;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Even parity over the held phase, compared to the following parity bit.
  assign mismatch     = lif.par != bpe_even_par(st_reg.ad, st_reg.cbe);
  assign lif.addr_err = st_reg.addr_ph & mismatch;
  assign lif.data_err = st_reg.data_ph & mismatch;
  assign lif.kind_q   = st_reg.kind;

  a_addr_checked: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (lif.addr_ph ##1 (lif.par != bpe_even_par($past(lif.ad),
                                              $past(lif.cbe))))
      |-> lif.addr_err)
    else $error("Address parity mismatch was not flagged.");

  a_data_clean: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (lif.data_ph ##1 (lif.par == bpe_even_par($past(lif.ad),
                                              $past(lif.cbe))))
      |-> !lif.data_err)
    else $error("Data parity error flagged on good parity.");

endmodule

// ===== bpe_lane_if.sv
// Purpose: Carries one bus's samples to a parity lane and its verdicts back.
// Assumes: All signals on the bridge clock.
// Notes:   One instance per bus.
`timescale 1ns/1ps
interface bpe_lane_if;
  import bpe_pkg::*;
  logic [31:0] ad;
  logic [3:0]  cbe;
  logic        par;
  logic        addr_ph;
  logic        data_ph;
  bpe_kind_t   kind;
  logic        addr_err;
  logic        data_err;
  bpe_kind_t   kind_q;

  modport lane (input ad, cbe, par, addr_ph, data_ph, kind,
                output addr_err, data_err, kind_q);
  modport user (output ad, cbe, par, addr_ph, data_ph, kind,
                input addr_err, data_err, kind_q);
endinterface

// ===== bpe_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the
//          bridge parity error unit.
// Assumes: Registers sit in one aligned 32-bit word each on AHB-Lite.
// Notes:   Definitions only.
`ifndef BPE_MAP_SVH
`define BPE_MAP_SVH

// Register byte offsets within the slave window.
`define BPE_OFS_CTRL       8'h00
`define BPE_OFS_PSTAT      8'h04
`define BPE_OFS_SSTAT      8'h08

// Control register fields.
`define BPE_CTRL_PRI_PER   0
`define BPE_CTRL_SERR_EN   1
`define BPE_CTRL_SEC_PER   2

// Primary status fields, write one to clear.
`define BPE_PSTAT_DET      0
`define BPE_PSTAT_SIG_SERR 1
`define BPE_PSTAT_DPD      2

// Secondary status fields, write one to clear.
`define BPE_SSTAT_DET      0
`define BPE_SSTAT_DPD      1

// Reset values.
`define BPE_CTRL_RESET     3'h0
`define BPE_PSTAT_RESET    3'h0
`define BPE_SSTAT_RESET    2'h0

// Error line delay after the data phase, in bus clock cycles.
`define BPE_PERR_DELAY_CYC 2
// Encoding of a word-sized AHB transfer.
`define BPE_HSIZE_WORD     3'h2

`endif

// ===== bpe_pci_agent.sv
// Purpose: PCI agent that presents one bus phase and its parity to a lane.
// Assumes: Parity of a phase follows one clock after the phase.
// Notes:   Released lines carry the inverse of the last value.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module bpe_pci_agent
  import bpe_pkg::*;
(
  // Clock
  input  wire logic   hclk,
  // Bus sample toward the bridge
  output logic [31:0] ad,
  output logic [3:0]  cbe,
  output logic        par,
  output logic        addr_phase,
  output logic        data_phase,
  output bpe_kind_t   kind,
  output logic        decode_hit
);
  localparam logic [31:0] AD_WORD  = 32'hA5C30F18;
  localparam logic [3:0]  CBE_WORD = 4'h6;
  initial begin
    ad = 32'h0;
    cbe = 4'h0;
    par = 1'b0;
    addr_phase = 1'b0;
    data_phase = 1'b0;
    kind = BPE_KIND_OTHER;
    decode_hit = 1'b0;
  end
  // Sends one phase; bad inverts the parity that follows it.
  task automatic send(input logic a, input bpe_kind_t k, input logic bad);
    @(posedge hclk);
    ad <= AD_WORD;
    cbe <= CBE_WORD;
    addr_phase <= a;
    data_phase <= ~a;
    kind <= k;
    @(posedge hclk);
    ad <= ~AD_WORD;
    cbe <= ~CBE_WORD;
    addr_phase <= 1'b0;
    data_phase <= 1'b0;
    kind <= BPE_KIND_OTHER;
    par <= (^{AD_WORD, CBE_WORD}) ^ bad;
    decode_hit <= a;
    @(posedge hclk);
    par <= ~par;
    decode_hit <= 1'b0;
  endtask
endmodule

// ===== bpe_pkg.sv
// Purpose: Types and shared parity function of the bridge parity error unit.
// Assumes: Even parity over 32 address/data and 4 command/enable lines.
// Notes:   Field order of the status structs matches the register layout.
package bpe_pkg;

  typedef enum logic [1:0] {
    BPE_KIND_OTHER,
    BPE_KIND_READ_IN,
    BPE_KIND_CFG_WR
  } bpe_kind_t;

  typedef struct packed {
    logic sec_per;
    logic serr_en;
    logic pri_per;
  } bpe_ctrl_t;

  typedef struct packed {
    logic dpd;
    logic sig_serr;
    logic det;
  } bpe_pstat_t;

  typedef struct packed {
    logic dpd;
    logic det;
  } bpe_sstat_t;

  typedef struct packed {
    logic [31:0] ad;
    logic [3:0]  cbe;
    logic        addr_ph;
    logic        data_ph;
    bpe_kind_t   kind;
  } bpe_lane_state_t;

  typedef struct packed {
    bpe_ctrl_t   ctrl;
    bpe_pstat_t  pstat;
    bpe_sstat_t  sstat;
    logic        wr_pend;
    logic [7:0]  wr_ofs;
    logic [31:0] hrdata;
    logic        primary_parity_error_n;
    logic        secondary_parity_error_n;
    logic        serr;
    logic        p_par;
    logic [1:0]  s_par;
  } bpe_state_t;

  function automatic logic bpe_even_par(input logic [31:0] ad,
                                        input logic [3:0]  cbe);
    return ^{ad, cbe};
  endfunction

endpackage

// ===== bpe_unit.sv
// Purpose: Parity checking, forwarding and error reporting of a three-port
//          bridge, with its control and status reached over AHB-Lite.
// Assumes: Bus samples come from the bridge's bus logic on the same clock.
// Notes:   Error lines are open-drain style: driven low while enabled.
`timescale 1ns/1ps
`include "bpe_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Check parity on all buses and forward parity with the data.
// - Address parity is checked on every transaction and every command.
// - Primary address parity error with response enabled suppresses claim.
// - Primary address parity error sets primary detected parity flag.
// - Primary address error raises system error if enable and response set.
// - Secondary address error suppresses secondary claims only with response enabled; sets detected flag.
// - Secondary address error raises system error if both enables set.
// - Forwarded data keeps its parity condition unchanged.
// - Config write parity error still completes; error line only if enabled.
// - Config write parity error always sets primary detected flag.
// - Bad secondary read data raises secondary error line two cycles later.
// - Downstream read error sets secondary detected and data parity flags.
// - Bad read data goes to the initiator with its bad parity.
// - Discarded prefetched bad data is never reported.
// - Bad primary read data raises primary error line two cycles later.
// - Upstream read error sets primary detected and data parity flags.
// - Read data and parity are returned as received, not regenerated.
// - An initiator's parity error on returned data causes no action.
module bpe_unit
  import bpe_pkg::*;
(
  // AHB-Lite slave
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Primary bus samples
  input  wire logic [31:0]           p_ad,
  input  wire logic [3:0]            p_cbe,
  input  wire logic                  p_par,
  input  wire logic                  p_addr_phase,
  input  wire logic                  p_data_phase,
  input  wire bpe_kind_t             p_kind,
  input  wire logic                  p_decode_hit,
  input  wire logic                  p_cfg_trdy,
  // Secondary bus samples, index 0 is bus one
  input  wire logic [1:0][31:0]      s_ad,
  input  wire logic [1:0][3:0]       s_cbe,
  input  wire logic [1:0]            s_par,
  input  wire logic [1:0]            s_addr_phase,
  input  wire logic [1:0]            s_data_phase,
  input  wire bpe_kind_t             s_kind [2],
  input  wire logic [1:0]            s_decode_hit,
  // Outgoing primary data
  input  wire logic [31:0]           p_out_ad,
  input  wire logic [3:0]            p_out_cbe,
  input  wire logic                  p_out_fwd,
  input  wire logic                  p_out_fwd_par,
  output logic                       p_par_out,
  // Outgoing secondary data
  input  wire logic [1:0][31:0]      s_out_ad,
  input  wire logic [1:0][3:0]       s_out_cbe,
  input  wire logic [1:0]            s_out_fwd,
  input  wire logic [1:0]            s_out_fwd_par,
  output logic [1:0]                 s_par_out,
  // Claim and target ready lines
  output logic                       primary_claim_n,
  output logic                       secondary_one_claim_n,
  output logic                       secondary_two_claim_n,
  output logic                       primary_target_ready_n,
  // Error lines
  output logic                       primary_parity_error_n_o,
  output logic                       primary_parity_error_n_oe,
  output logic                       secondary_parity_error_n_o,
  output logic                       secondary_parity_error_n_oe,
  output logic                       primary_system_error_n_o,
  output logic                       primary_system_error_n_oe
);

  //////////////////////////////////////////////////////////////////////////////
  // Parity lanes.

  bpe_lane_if p_lif ();
  bpe_lane_if s_lif [2] ();

  logic [1:0] s_aerr;
  logic [1:0] s_derr;
  logic [1:0] s_rd_err;

  assign p_lif.ad      = p_ad;
  assign p_lif.cbe     = p_cbe;
  assign p_lif.par     = p_par;
  assign p_lif.addr_ph = p_addr_phase;
  assign p_lif.data_ph = p_data_phase;
  assign p_lif.kind    = p_kind;

  bpe_lane u_p_lane (
    .hclk    (hclk),
    .hresetn (hresetn),
    .lif     (p_lif.lane)
  );

  for (genvar g = 0; g < 2; g++) begin : g_sec
    assign s_lif[g].ad      = s_ad[g];
    assign s_lif[g].cbe     = s_cbe[g];
    assign s_lif[g].par     = s_par[g];
    assign s_lif[g].addr_ph = s_addr_phase[g];
    assign s_lif[g].data_ph = s_data_phase[g];
    assign s_lif[g].kind    = s_kind[g];
    assign s_aerr[g]        = s_lif[g].addr_err;
    assign s_derr[g]        = s_lif[g].data_err;
    assign s_rd_err[g]      = s_lif[g].data_err &
                              (s_lif[g].kind_q == BPE_KIND_READ_IN);

    bpe_lane u_s_lane (
      .hclk    (hclk),
      .hresetn (hresetn),
      .lif     (s_lif[g].lane)
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register access helpers.

  function automatic logic [31:0] rd_word(input logic [7:0] ofs,
                                          input bpe_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (ofs)
      `BPE_OFS_CTRL: begin
        w[`BPE_CTRL_PRI_PER] = s.ctrl.pri_per;
        w[`BPE_CTRL_SERR_EN] = s.ctrl.serr_en;
        w[`BPE_CTRL_SEC_PER] = s.ctrl.sec_per;
      end
      `BPE_OFS_PSTAT: begin
        w[`BPE_PSTAT_DET]      = s.pstat.det;
        w[`BPE_PSTAT_SIG_SERR] = s.pstat.sig_serr;
        w[`BPE_PSTAT_DPD]      = s.pstat.dpd;
      end
      `BPE_OFS_SSTAT: begin
        w[`BPE_SSTAT_DET] = s.sstat.det;
        w[`BPE_SSTAT_DPD] = s.sstat.dpd;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Event decode and state update.

  bpe_state_t st_reg;
  bpe_state_t st_next;

  logic       p_aerr;
  logic       p_rd_err;
  logic       p_cfg_err;
  logic       sec_aerr;
  logic       sec_rd_err;
  logic       addr_accept;
  logic       serr_fire;
  bpe_pstat_t pset;
  bpe_sstat_t sset;
  bpe_pstat_t pclr;
  bpe_sstat_t sclr;

  assign p_aerr     = p_lif.addr_err;
  assign p_rd_err   = p_lif.data_err & (p_lif.kind_q == BPE_KIND_READ_IN);
  assign p_cfg_err  = p_lif.data_err & (p_lif.kind_q == BPE_KIND_CFG_WR);
  assign sec_aerr   = |s_aerr;
  assign sec_rd_err = |s_rd_err;
  assign addr_accept = hsel & htrans[1] & hready;

  // System error on address parity from either side, gated per side.
  assign serr_fire = st_reg.ctrl.serr_en &
                     ((p_aerr & st_reg.ctrl.pri_per) |
                      (sec_aerr & st_reg.ctrl.sec_per));

  always_comb begin
    st_next = st_reg;
    pset    = '0;
    sset    = '0;
    pclr    = '0;
    sclr    = '0;

    // Flags set only by the bridge's own checks; a parity error line
    // raised by an initiator on returned data is not watched at all.
    pset.det      = p_aerr | p_cfg_err | p_rd_err;
    pset.sig_serr = serr_fire;
    pset.dpd      = p_rd_err & st_reg.ctrl.pri_per;
    sset.det      = sec_aerr | sec_rd_err;
    sset.dpd      = sec_rd_err & st_reg.ctrl.sec_per;

    // Data phase write of the transfer taken last cycle.
    st_next.wr_pend = 1'b0;
    if (st_reg.wr_pend) begin
      case (st_reg.wr_ofs)
        `BPE_OFS_CTRL: begin
          st_next.ctrl.pri_per = hwdata[`BPE_CTRL_PRI_PER];
          st_next.ctrl.serr_en = hwdata[`BPE_CTRL_SERR_EN];
          st_next.ctrl.sec_per = hwdata[`BPE_CTRL_SEC_PER];
        end
        `BPE_OFS_PSTAT: begin
          pclr.det      = hwdata[`BPE_PSTAT_DET];
          pclr.sig_serr = hwdata[`BPE_PSTAT_SIG_SERR];
          pclr.dpd      = hwdata[`BPE_PSTAT_DPD];
        end
        `BPE_OFS_SSTAT: begin
          sclr.det = hwdata[`BPE_SSTAT_DET];
          sclr.dpd = hwdata[`BPE_SSTAT_DPD];
        end
        default: begin
          st_next.ctrl = st_reg.ctrl;
        end
      endcase
    end

    // An event in the clearing cycle survives the clear.
    st_next.pstat = (st_reg.pstat & ~pclr) | pset;
    st_next.sstat = (st_reg.sstat & ~sclr) | sset;

    // Address phase: writes wait for data, reads are answered at once.
    if (addr_accept) begin
      st_next.wr_pend = hwrite & (hsize == `BPE_HSIZE_WORD);
      st_next.wr_ofs  = haddr[7:0];
      if (!hwrite) begin
        st_next.hrdata = rd_word(haddr[7:0], st_next);
      end
    end

    // Parity error lines land two cycles after the data phase, the system error line two after the address phase.
    st_next.primary_parity_error_n = st_reg.ctrl.pri_per &
                     (p_rd_err | p_cfg_err);
    st_next.secondary_parity_error_n = st_reg.ctrl.sec_per & sec_rd_err;
    st_next.serr   = serr_fire;

    // Forwarded data keeps the parity it arrived with; own data is
    // given fresh even parity.
    st_next.p_par = p_out_fwd ? p_out_fwd_par
                              : bpe_even_par(p_out_ad, p_out_cbe);
    for (int i = 0; i < 2; i++) begin
      st_next.s_par[i] = s_out_fwd[i] ? s_out_fwd_par[i]
                                      : bpe_even_par(s_out_ad[i],
                                                     s_out_cbe[i]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg       <= '0;
      st_reg.ctrl  <= `BPE_CTRL_RESET;
      st_reg.pstat <= `BPE_PSTAT_RESET;
      st_reg.sstat <= `BPE_SSTAT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_reg.hrdata;

  // Claims are withheld on address parity error only when response is on.
  assign primary_claim_n =
    ~(p_decode_hit & ~(p_aerr & st_reg.ctrl.pri_per));
  assign secondary_one_claim_n =
    ~(s_decode_hit[0] & ~(s_aerr[0] & st_reg.ctrl.sec_per));
  assign secondary_two_claim_n =
    ~(s_decode_hit[1] & ~(s_aerr[1] & st_reg.ctrl.sec_per));

  // Configuration writes complete even with bad data parity.
  assign primary_target_ready_n = ~p_cfg_trdy;

  // Prefetched data that is never driven out never reaches these lines.
  assign primary_parity_error_n_o    = ~st_reg.primary_parity_error_n;
  assign primary_parity_error_n_oe   = st_reg.primary_parity_error_n;
  assign secondary_parity_error_n_o  = ~st_reg.secondary_parity_error_n;
  assign secondary_parity_error_n_oe = st_reg.secondary_parity_error_n;
  assign primary_system_error_n_o    = ~st_reg.serr;
  assign primary_system_error_n_oe   = st_reg.serr;
  assign p_par_out                   = st_reg.p_par;
  assign s_par_out                   = st_reg.s_par;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_pri_claim_gate: assert property (
    (p_decode_hit && p_aerr && st_reg.ctrl.pri_per) |-> primary_claim_n)
    else $error("Primary claimed despite address parity error.");

  a_pri_claim_open: assert property (
    (p_decode_hit && !st_reg.ctrl.pri_per) |-> !primary_claim_n)
    else $error("Primary claim lost with parity response off.");

  a_sec_claim_gate: assert property (
    (s_decode_hit[1] && s_aerr[1] && st_reg.ctrl.sec_per)
      |-> secondary_two_claim_n)
    else $error("Secondary claimed despite address parity error.");

  a_pri_det_flag: assert property (
    p_aerr |=> st_reg.pstat.det)
    else $error("Primary detected flag not set on address error.");

  a_serr_primary: assert property (
    (p_aerr && st_reg.ctrl.pri_per && st_reg.ctrl.serr_en)
      |=> (primary_system_error_n_oe && !primary_system_error_n_o
           && st_reg.pstat.sig_serr))
    else $error("System error missing on primary address error.");

  a_serr_quiet: assert property (
    !st_reg.ctrl.serr_en |=> !primary_system_error_n_oe)
    else $error("System error driven while disabled.");

  a_serr_secondary: assert property (
    (sec_aerr && st_reg.ctrl.sec_per && st_reg.ctrl.serr_en)
      |=> primary_system_error_n_oe)
    else $error("System error missing on secondary address error.");

  a_sec_perr_time: assert property (
    (s_data_phase[0] && s_kind[0] == BPE_KIND_READ_IN
     && st_reg.ctrl.sec_per)
      ##1 (s_par[0] != bpe_even_par($past(s_ad[0]), $past(s_cbe[0]))
           && st_reg.ctrl.sec_per)
      |=> secondary_parity_error_n_oe && !secondary_parity_error_n_o)
    else $error("Secondary error line not two cycles after bad read.");

  a_sec_rd_flags: assert property (
    (sec_rd_err && st_reg.ctrl.sec_per)
      |=> (st_reg.sstat.det && st_reg.sstat.dpd))
    else $error("Secondary flags not set on downstream read error.");

  a_pri_perr_time: assert property (
    (p_rd_err && st_reg.ctrl.pri_per) |=> primary_parity_error_n_oe)
    else $error("Primary error line late on upstream read error.");

  a_pri_rd_flags: assert property (
    (p_rd_err && !st_reg.ctrl.pri_per)
      |=> (st_reg.pstat.det && !$rose(st_reg.pstat.dpd)))
    else $error("Primary read flags wrong with response off.");

  a_cfg_no_perr: assert property (
    (p_cfg_err && !st_reg.ctrl.pri_per && !p_rd_err)
      |=> (!primary_parity_error_n_oe && st_reg.pstat.det))
    else $error("Config write parity handling wrong with response off.");

  a_par_forward: assert property (
    p_out_fwd |=> (p_par_out == $past(p_out_fwd_par)))
    else $error("Forwarded parity was regenerated.");

  a_par_generate: assert property (
    !s_out_fwd[0]
      |=> (s_par_out[0] == bpe_even_par($past(s_out_ad[0]),
                                        $past(s_out_cbe[0]))))
    else $error("Generated parity is not even.");

endmodule

// ===== bpe_unit_test.sv
// Purpose: Self-checking bench of the bridge parity error unit.
// Assumes: Zero-wait AHB-Lite slave; agents stand in for the PCI buses.
// Notes:   Each event case sets control, runs one phase, checks all lines.
`timescale 1ns/1ps
`include "bpe_map.svh"
////////////////////////////////////////////////////////////////////////////
module bpe_unit_test
  import bpe_pkg::*;
;
  localparam bpe_kind_t k_oth = BPE_KIND_OTHER;
  localparam bpe_kind_t k_rd  = BPE_KIND_READ_IN;
  localparam bpe_kind_t k_cfg = BPE_KIND_CFG_WR;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        p_cfg_trdy = 1'b0;
  logic [31:0] od = 32'h0;
  logic        of = 1'b0;
  logic        ofp = 1'b0;
  int          n_fail = 0;
  int          check_count = 0;
  wire logic [31:0] hrdata;
  wire logic        hreadyout, hresp, trdy_n;
  wire logic [31:0] ad [3];
  wire logic [3:0]  cbe [3];
  wire bpe_kind_t   kind [3];
  wire bpe_kind_t   s_kind [2];
  wire logic [2:0]  par, aph, dph, hit, po, cl, lo, le;
  assign s_kind[0] = kind[1];
  assign s_kind[1] = kind[2];
  always #25 hclk = ~hclk;
  for (genvar i = 0; i < 3; i++) begin : g_ag
    bpe_pci_agent u_ag (.hclk(hclk), .ad(ad[i]), .cbe(cbe[i]),
      .par(par[i]), .addr_phase(aph[i]), .data_phase(dph[i]),
      .kind(kind[i]), .decode_hit(hit[i]));
  end
  bpe_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(`BPE_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .p_ad(ad[0]), .p_cbe(cbe[0]), .p_par(par[0]), .p_addr_phase(aph[0]),
    .p_data_phase(dph[0]), .p_kind(kind[0]), .p_decode_hit(hit[0]),
    .p_cfg_trdy(p_cfg_trdy), .s_ad({ad[2], ad[1]}),
    .s_cbe({cbe[2], cbe[1]}), .s_par(par[2:1]), .s_addr_phase(aph[2:1]),
    .s_data_phase(dph[2:1]), .s_kind(s_kind), .s_decode_hit(hit[2:1]),
    .p_out_ad(od), .p_out_cbe(od[3:0]), .p_out_fwd(of),
    .p_out_fwd_par(ofp), .p_par_out(po[0]), .s_out_ad({od, od}),
    .s_out_cbe({od[3:0], od[3:0]}), .s_out_fwd({of, of}),
    .s_out_fwd_par({ofp, ofp}), .s_par_out(po[2:1]),
    .primary_claim_n(cl[2]), .secondary_one_claim_n(cl[1]),
    .secondary_two_claim_n(cl[0]), .primary_target_ready_n(trdy_n),
    .primary_parity_error_n_o(lo[2]), .primary_parity_error_n_oe(le[2]),
    .secondary_parity_error_n_o(lo[1]),
    .secondary_parity_error_n_oe(le[1]),
    .primary_system_error_n_o(lo[0]), .primary_system_error_n_oe(le[0]));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single AHB-Lite transfer; read data taken at the data phase edge.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  // Runs one phase on bus b under control c; checks claims, lines, flags.
  task automatic ev(input int b, input logic a, input bpe_kind_t k,
    input logic bad, input logic [2:0] c, input logic [2:0] ec,
    input logic [2:0] ln, input logic [2:0] ps, input logic [1:0] ss);
    wr(`BPE_OFS_CTRL, {29'h0, c});
    fork
      case (b)
        0: g_ag[0].u_ag.send(a, k, bad);
        1: g_ag[1].u_ag.send(a, k, bad);
        default: g_ag[2].u_ag.send(a, k, bad);
      endcase
      begin
        @(posedge hclk);
        p_cfg_trdy <= (k == k_cfg);
        @(posedge hclk);
        @(negedge hclk);
        chk({28'h0, cl, trdy_n}, {28'h0, ec, ~(k == k_cfg)});
        @(negedge hclk);
        chk({26'h0, le, lo}, {26'h0, ln, ~ln});
      end
    join
    rd(`BPE_OFS_PSTAT, {29'h0, ps});
    rd(`BPE_OFS_SSTAT, {30'h0, ss});
    wr(`BPE_OFS_PSTAT, 32'h7);
    wr(`BPE_OFS_SSTAT, 32'h3);
  endtask
  // Outgoing parity: the arrived bit when forwarded, else generated even.
  task automatic fw(input logic [31:0] d, input logic f, input logic fp);
    @(posedge hclk);
    od <= d;
    of <= f;
    ofp <= fp;
    @(posedge hclk);
    @(negedge hclk);
    chk({29'h0, po}, {29'h0, {3{f ? fp : ^{d, d[3:0]}}}});
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge hclk);
    chk({26'h0, le, lo}, {26'h0, 3'h0, 3'h7});
    hresetn <= 1'b1;
    rd(`BPE_OFS_CTRL, 32'h0);
    rd(`BPE_OFS_PSTAT, 32'h0);
    rd(`BPE_OFS_SSTAT, 32'h0);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h0);
    wr(`BPE_OFS_CTRL, 32'h7);
    rd(`BPE_OFS_CTRL, 32'h7);
    ev(0, 1, k_oth, 0, 3'h3, 3'b011, 3'b000, 3'h0, 2'h0);
    ev(0, 1, k_oth, 1, 3'h0, 3'b011, 3'b000, 3'h1, 2'h0);
    ev(0, 1, k_oth, 1, 3'h1, 3'b111, 3'b000, 3'h1, 2'h0);
    ev(0, 1, k_oth, 1, 3'h3, 3'b111, 3'b001, 3'h3, 2'h0);
    ev(0, 1, k_oth, 1, 3'h2, 3'b011, 3'b000, 3'h1, 2'h0);
    ev(2, 1, k_oth, 1, 3'h0, 3'b110, 3'b000, 3'h0, 2'h1);
    ev(2, 1, k_oth, 1, 3'h4, 3'b111, 3'b000, 3'h0, 2'h1);
    ev(1, 1, k_oth, 1, 3'h6, 3'b111, 3'b001, 3'h2, 2'h1);
    ev(1, 1, k_oth, 1, 3'h3, 3'b101, 3'b000, 3'h0, 2'h1);
    ev(0, 0, k_rd, 1, 3'h1, 3'b111, 3'b100, 3'h5, 2'h0);
    ev(0, 0, k_rd, 1, 3'h6, 3'b111, 3'b000, 3'h1, 2'h0);
    ev(1, 0, k_rd, 1, 3'h4, 3'b111, 3'b010, 3'h0, 2'h3);
    ev(2, 0, k_rd, 1, 3'h3, 3'b111, 3'b000, 3'h0, 2'h1);
    ev(0, 0, k_cfg, 1, 3'h1, 3'b111, 3'b100, 3'h1, 2'h0);
    ev(0, 0, k_cfg, 1, 3'h0, 3'b111, 3'b000, 3'h1, 2'h0);
    ev(0, 0, k_oth, 1, 3'h7, 3'b111, 3'b000, 3'h0, 2'h0);
    ev(1, 0, k_rd, 0, 3'h7, 3'b111, 3'b000, 3'h0, 2'h0);
    fw(32'h00000010, 1'b1, 1'b0);
    fw(32'h00000003, 1'b1, 1'b1);
    fw(32'h00000010, 1'b0, 1'b0);
    fw(32'h00000003, 1'b0, 1'b1);
    final_report();
  end
endmodule
